// File: cardbus_cfg_pkg.sv
/*
  Constants shared by the card-bridge configuration header: header offsets,
  fixed values, reset values, secondary status layout and state encodings.
  Assumes byte addresses of configuration space as seen by the host.
*/
package cardbus_cfg_pkg;

  localparam int NUM_FUNC = 2;

  // Byte offsets within the 256-byte configuration space.
  localparam logic [7:0] OFF_CACHE_LINE_SIZE = 8'h0C;
  localparam logic [7:0] OFF_LATENCY_LIMIT = 8'h0D;
  localparam logic [7:0] OFF_HEADER_TYPE = 8'h0E;
  localparam logic [7:0] OFF_SELF_TEST = 8'h0F;
  localparam logic [7:0] OFF_SOCKET_BASE = 8'h10;
  localparam logic [7:0] OFF_CAP_POINTER = 8'h14;
  localparam logic [7:0] OFF_CARD_STATUS = 8'h16;
  localparam logic [7:0] OFF_EXT_START = 8'h80;
  localparam logic [7:0] OFF_PM_CAP = 8'hA0;
  localparam logic [7:0] OFF_PM_CTRL = 8'hA4;

  // Fixed read values.
  localparam logic [7:0] HEADER_TYPE_VALUE = 8'h82;
  localparam logic [7:0] SELF_TEST_VALUE = 8'h00;
  localparam logic [7:0] CAP_POINTER_VALUE = 8'hA0;

  // Reset values.
  localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
  localparam logic [7:0] LATENCY_RESET = 8'h00;
  localparam logic [31:0] SOCKET_BASE_RESET = 32'h00000000;
  localparam logic [15:0] CARD_STATUS_RESET = 16'h0200;

  // Base address: only bits 31..12 hold state, giving a 4-Kbyte window.
  localparam logic [31:0] SOCKET_BASE_WR_MASK = 32'hFFFFF000;
  localparam int BASE_LSB = 12;
  localparam logic [11:0] WINDOW_SOCKET_OFFSET = 12'h000;
  localparam logic [11:0] WINDOW_LEGACY_OFFSET = 12'h800;

  // Secondary status bit positions.
  localparam int ST_PARITY = 15;
  localparam int ST_SYSTEM_ERR = 14;
  localparam int ST_MASTER_ABORT = 13;
  localparam int ST_TARGET_ABORT_RX = 12;
  localparam int ST_TARGET_ABORT_TX = 11;
  localparam int ST_DATA_PARITY = 8;
  localparam logic [15:0] CARD_STATUS_RC_MASK = 16'hF900;

  typedef enum logic [0:0] {
    CFG_IDLE = 1'b0,
    CFG_ANSWER = 1'b1
  } cfg_state_e;

  typedef enum logic [1:0] {
    LAT_IDLE = 2'b00,
    LAT_COUNT = 2'b01,
    LAT_EXPIRED = 2'b10
  } lat_state_e;

endpackage

// File: initiator_latency_timer.sv
/*
  Initiator latency timer of one function, counting clocks from its frame.
  Assumes frame_start and transaction_done come from the master logic.
*/
`timescale 1ns/1ps
module initiator_latency_timer
  import cardbus_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Programmed limit
  input wire logic [7:0] latency_limit,
  // Master activity
  input wire logic frame_start,
  input wire logic transaction_done,
  input wire logic gnt_n,
  // Result
  output logic timer_expired,
  output logic terminate_now
);

  lat_state_e state;
  logic [7:0] count;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= LAT_IDLE;
      count <= 8'h00;
    end
    else if (frame_start)
    begin
      state <= LAT_COUNT;
      count <= 8'h00;
    end
    else
    begin
      unique case (state)
        LAT_IDLE:
        begin
          count <= 8'h00;
        end
        LAT_COUNT:
        begin
          if (transaction_done)
          begin
            state <= LAT_IDLE;
          end
          else if (count >= latency_limit)
          begin
            state <= LAT_EXPIRED;
          end
          else
          begin
            count <= count + 8'h01;
          end
        end
        LAT_EXPIRED:
        begin
          if (transaction_done)
          begin
            state <= LAT_IDLE;
          end
        end
        default:
        begin
          state <= LAT_IDLE;
        end
      endcase
    end
  end

  assign timer_expired = (state == LAT_EXPIRED);
  // Grant is active low, so a high gnt_n means the arbiter took it away.
  assign terminate_now = timer_expired && gnt_n && !transaction_done;

endmodule

// File: card_side_status.sv
/*
  Secondary status register of one socket function. Error bits are sticky
  and cleared by writing one; the remaining bits are constants.
  Assumes clear_mask is nonzero only in the cycle of a configuration write.
*/
`timescale 1ns/1ps
module card_side_status
  import cardbus_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Card-side events, one-cycle or level
  input wire logic card_parity_detected,
  input wire logic card_system_error,
  input wire logic card_master_abort_received,
  input wire logic card_target_abort_received,
  input wire logic card_target_abort_signaled,
  input wire logic card_parity_signal,
  input wire logic card_bus_master,
  input wire logic parity_response_en,
  // Write-one-to-clear mask from the configuration port
  input wire logic [15:0] clear_mask,
  // Register value
  output logic [15:0] status
);

  logic [15:0] set_event;

  always_comb
  begin
    set_event = 16'h0000;
    set_event[ST_PARITY] = card_parity_detected;
    set_event[ST_SYSTEM_ERR] = card_system_error;
    set_event[ST_MASTER_ABORT] = card_master_abort_received;
    set_event[ST_TARGET_ABORT_RX] = card_target_abort_received;
    set_event[ST_TARGET_ABORT_TX] = card_target_abort_signaled;
    set_event[ST_DATA_PARITY] = card_parity_signal && card_bus_master
                                && parity_response_en;
  end

  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_bit
      if (CARD_STATUS_RC_MASK[i])
      begin : g_sticky
        logic flag;
        // A new event in the clearing cycle keeps the flag set.
        always_ff @(posedge ref_clk or negedge rstn)
        begin
          if (!rstn)
          begin
            flag <= CARD_STATUS_RESET[i];
          end
          else if (set_event[i])
          begin
            flag <= 1'b1;
          end
          else if (clear_mask[i])
          begin
            flag <= 1'b0;
          end
        end
        assign status[i] = flag;
      end
      else
      begin : g_fixed
        assign status[i] = CARD_STATUS_RESET[i];
      end
    end
  endgenerate

endmodule

// File: cardbus_bridge_config_header.sv
/*
  Configuration header slice of a dual-socket card bridge, one register set
  per socket function, plus the memory window decode of the base registers.
  Assumes one access at a time, as a one-cycle cfg_req answered by cfg_ack.
*/
`timescale 1ns/1ps
module cardbus_bridge_config_header
  import cardbus_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration access from the host side
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Extension space, served outside this block
  output logic ext_sel,
  output logic pm_sel,
  input wire logic [31:0] ext_rdata,
  // Memory window decode
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [NUM_FUNC-1:0] mem_space_en,
  output logic [NUM_FUNC-1:0] socket_reg_hit,
  output logic [NUM_FUNC-1:0] legacy_reg_hit,
  // Initiator activity per function
  input wire logic [NUM_FUNC-1:0] init_frame_start,
  input wire logic [NUM_FUNC-1:0] init_done,
  input wire logic gnt_n,
  output logic [NUM_FUNC-1:0] latency_expired,
  output logic [NUM_FUNC-1:0] terminate_req,
  // Card-side events per socket
  input wire logic [NUM_FUNC-1:0] card_parity_detected,
  input wire logic [NUM_FUNC-1:0] card_system_error,
  input wire logic [NUM_FUNC-1:0] card_master_abort_received,
  input wire logic [NUM_FUNC-1:0] card_target_abort_received,
  input wire logic [NUM_FUNC-1:0] card_target_abort_signaled,
  input wire logic [NUM_FUNC-1:0] card_parity_signal,
  input wire logic [NUM_FUNC-1:0] card_bus_master,
  input wire logic [NUM_FUNC-1:0] parity_response_en,
  // Register values for the rest of the function
  output logic [7:0] cache_line_size [NUM_FUNC],
  output logic [7:0] initiator_latency_limit [NUM_FUNC],
  output logic [31:0] socket_window_base [NUM_FUNC]
);

  // Replaces the enabled byte lanes of old with those of data.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [3:0] be,
                                             input logic [31:0] data);
    logic [31:0] result;
    result = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        result[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return result;
  endfunction

  // True when a byte address falls in the given dword.
  function automatic logic dword_is(input logic [7:0] addr, input logic [7:0] offset);
    return addr[7:2] == offset[7:2];
  endfunction

  localparam logic [3:0] LANES_NONE = 4'h0;

  cfg_state_e cfg_state;
  logic [15:0] card_status [NUM_FUNC];
  logic [15:0] status_clear [NUM_FUNC];
  logic [31:0] next_rdata;
  logic hit_misc;
  logic hit_base;
  logic hit_cap;
  logic hit_ext;
  logic wr_req;
  logic [3:0] misc_lanes;
  logic [3:0] base_lanes;
  logic [3:0] cap_lanes;

  // Address decode of the access in flight.
  assign hit_misc = dword_is(cfg_addr, OFF_CACHE_LINE_SIZE);
  assign hit_base = dword_is(cfg_addr, OFF_SOCKET_BASE);
  assign hit_cap = dword_is(cfg_addr, OFF_CAP_POINTER);
  assign hit_ext = (cfg_addr >= OFF_EXT_START);
  assign wr_req = cfg_req && cfg_write;
  assign misc_lanes = (wr_req && hit_misc) ? cfg_byte_en : LANES_NONE;
  assign base_lanes = (wr_req && hit_base) ? cfg_byte_en : LANES_NONE;
  assign cap_lanes = (wr_req && hit_cap) ? cfg_byte_en : LANES_NONE;

  // Extension space, power-management dwords included, is served outside.
  assign ext_sel = cfg_req && hit_ext;
  assign pm_sel = cfg_req && (dword_is(cfg_addr, OFF_PM_CAP)
                              || dword_is(cfg_addr, OFF_PM_CTRL));

  genvar f;
  generate
    for (f = 0; f < NUM_FUNC; f++)
    begin : g_func
      logic sel;
      logic [31:0] base_word;
      logic window_hit;

      assign sel = (cfg_func == 1'(f));
      assign base_word = lane_merge(socket_window_base[f], base_lanes, cfg_wdata);

      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          cache_line_size[f] <= CACHE_LINE_RESET;
        end
        else if (sel && misc_lanes[0])
        begin
          cache_line_size[f] <= cfg_wdata[7:0];
        end
      end

      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          initiator_latency_limit[f] <= LATENCY_RESET;
        end
        else if (sel && misc_lanes[1])
        begin
          initiator_latency_limit[f] <= cfg_wdata[15:8];
        end
      end

      // Only bits 31..12 are stored, so low bits can never read back non-zero.
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          socket_window_base[f] <= SOCKET_BASE_RESET;
        end
        else if (sel && (base_lanes != LANES_NONE))
        begin
          socket_window_base[f] <= base_word & SOCKET_BASE_WR_MASK;
        end
      end

      // Clear requests only reach the socket addressed by the access.
      assign status_clear[f] = sel ? {cap_lanes[3] ? cfg_wdata[31:24] : 8'h00,
                                      cap_lanes[2] ? cfg_wdata[23:16] : 8'h00} : 16'h0000;

      card_side_status u_status (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .card_parity_detected(card_parity_detected[f]),
        .card_system_error(card_system_error[f]),
        .card_master_abort_received(card_master_abort_received[f]),
        .card_target_abort_received(card_target_abort_received[f]),
        .card_target_abort_signaled(card_target_abort_signaled[f]),
        .card_parity_signal(card_parity_signal[f]),
        .card_bus_master(card_bus_master[f]),
        .parity_response_en(parity_response_en[f]),
        .clear_mask(status_clear[f]),
        .status(card_status[f])
      );

      initiator_latency_timer u_latency (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .latency_limit(initiator_latency_limit[f]),
        .frame_start(init_frame_start[f]),
        .transaction_done(init_done[f]),
        .gnt_n(gnt_n),
        .timer_expired(latency_expired[f]),
        .terminate_now(terminate_req[f])
      );

      // The window is 4 Kbytes; bit 11 splits socket and legacy registers.
      assign window_hit = mem_valid && mem_space_en[f]
                          && (mem_addr[31:BASE_LSB] == socket_window_base[f][31:BASE_LSB]);
      assign socket_reg_hit[f] = window_hit
                                 && (mem_addr[11:0] >= WINDOW_SOCKET_OFFSET)
                                 && (mem_addr[11:0] < WINDOW_LEGACY_OFFSET);
      assign legacy_reg_hit[f] = window_hit
                                 && (mem_addr[11:0] >= WINDOW_LEGACY_OFFSET);
    end
  endgenerate

  // Read multiplexer; unimplemented header dwords read as zero.
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (hit_ext)
    begin
      next_rdata = ext_rdata;
    end
    else if (hit_misc)
    begin
      next_rdata = {SELF_TEST_VALUE, HEADER_TYPE_VALUE,
                    initiator_latency_limit[cfg_func], cache_line_size[cfg_func]};
    end
    else if (hit_base)
    begin
      next_rdata = socket_window_base[cfg_func];
    end
    else if (hit_cap)
    begin
      next_rdata = {card_status[cfg_func], 8'h00, CAP_POINTER_VALUE};
    end
  end

  // Every access gets an answer one clock later; read-only lanes drop silently.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_state <= CFG_IDLE;
    end
    else
    begin
      unique case (cfg_state)
        CFG_IDLE:
        begin
          if (cfg_req)
          begin
            cfg_state <= CFG_ANSWER;
          end
        end
        CFG_ANSWER:
        begin
          cfg_state <= cfg_req ? CFG_ANSWER : CFG_IDLE;
        end
      endcase
    end
  end

  assign cfg_ack = (cfg_state == CFG_ANSWER);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_rdata <= 32'h00000000;
    end
    else if (cfg_req)
    begin
      cfg_rdata <= cfg_write ? 32'h00000000 : next_rdata;
    end
  end

endmodule

// File: cfg_host_model.sv
/*
  Host-side partner: one configuration cycle at a time, and an
  address-derived pattern served behind ext_sel.
  Assumes the pulse request and one-cycle answer of the port.
*/
`timescale 1ns/1ps
module cfg_host_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration port
  output logic cfg_req,
  output logic cfg_write,
  output logic cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_byte_en,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  // Extension space
  input wire logic ext_sel,
  output logic [31:0] ext_rdata
);
  logic [31:0] noise;

  initial
  begin
    cfg_req = 1'b0;
    cfg_write = 1'b0;
    cfg_func = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
  end

  // An unselected extension bus must not look like stale valid data.
  always @(posedge ref_clk)
    noise <= rstn ? noise + 32'h01010101 : 32'h0;
  assign ext_rdata = ext_sel ? {~cfg_addr, cfg_addr, 16'hC35A} : noise;

  // The request is a pulse; the answer is taken at the edge ending the ack cycle.
  task automatic access(input logic wr, input logic fn, input logic [7:0] addr,
      input logic [3:0] be, input logic [31:0] wdata, output logic ok);
    @(posedge ref_clk);
    cfg_req <= 1'b1;
    cfg_write <= wr;
    cfg_func <= fn;
    cfg_addr <= addr;
    cfg_byte_en <= be;
    cfg_wdata <= wdata;
    @(posedge ref_clk);
    cfg_req <= 1'b0;
    @(posedge ref_clk);
    ok = (cfg_ack === 1'b1);
  endtask
endmodule

// File: cardbus_cfg_asserts.sv
/*
  Checker of the configuration header slice, bound to its top module.
  Assumes two functions and a one-cycle request port.
*/
`timescale 1ns/1ps
module cardbus_cfg_asserts
  import cardbus_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration port
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic ext_sel,
  input wire logic pm_sel,
  // Window decode
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [NUM_FUNC-1:0] mem_space_en,
  input wire logic [NUM_FUNC-1:0] socket_reg_hit,
  input wire logic [NUM_FUNC-1:0] legacy_reg_hit,
  // Latency timer
  input wire logic [NUM_FUNC-1:0] init_frame_start,
  input wire logic [NUM_FUNC-1:0] init_done,
  input wire logic gnt_n,
  input wire logic [NUM_FUNC-1:0] latency_expired,
  input wire logic [NUM_FUNC-1:0] terminate_req,
  // Register values
  input wire logic [7:0] cache_line_size [NUM_FUNC],
  input wire logic [7:0] initiator_latency_limit [NUM_FUNC],
  input wire logic [31:0] socket_window_base [NUM_FUNC]
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [8:0] lat_cnt;
  logic rd_req;
  logic [1:0] win;

  // Saturates, so a stuck timer still shows.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      lat_cnt <= 9'h000;
    else if (init_frame_start[0])
      lat_cnt <= 9'h000;
    else if (lat_cnt != 9'h1FF)
      lat_cnt <= lat_cnt + 9'h001;
  end

  assign rd_req = cfg_req && !cfg_write;
  assign win[0] = mem_valid && mem_space_en[0]
    && mem_addr[31:12] == socket_window_base[0][31:12];
  assign win[1] = mem_valid && mem_space_en[1]
    && mem_addr[31:12] == socket_window_base[1][31:12];

  chk_ack_after_req: assert property (cfg_req |=> cfg_ack)
    else $error("no answer after request");
  chk_ack_has_cause: assert property (cfg_ack |-> $past(cfg_req))
    else $error("answer without request");
  chk_header_dword: assert property (rd_req && cfg_addr[7:2] == 6'h03 |=> cfg_rdata[31:16] == 16'h0082)
    else $error("header type or self-test byte wrong");
  chk_cap_status_fixed: assert property (rd_req && cfg_addr[7:2] == 6'h05 |=> cfg_rdata[15:0] == 16'h00A0
    && cfg_rdata[26:25] == 2'b01 && cfg_rdata[23:16] == 8'h00)
    else $error("pointer or fixed status bits wrong");
  chk_base_low_zero: assert property (socket_window_base[0][11:0] == 12'h000
    && socket_window_base[1][11:0] == 12'h000)
    else $error("base low bits not zero");
  chk_ext_decode: assert property (ext_sel == (cfg_req && cfg_addr[7]))
    else $error("extension select wrong");
  chk_pm_decode: assert property (pm_sel == (cfg_req && cfg_addr[7:3] == 5'h14))
    else $error("power block select wrong");
  chk_window_split: assert property (socket_reg_hit == (win & {2{!mem_addr[11]}})
    && legacy_reg_hit == (win & {2{mem_addr[11]}}))
    else $error("window decode wrong");
  chk_expiry_time: assert property ($rose(latency_expired[0])
    |-> lat_cnt == {1'b0, initiator_latency_limit[0]} + 9'h001)
    else $error("latency expiry at wrong cycle");
  chk_terminate_grant: assert property (terminate_req[0]
    == (latency_expired[0] && gnt_n && !init_done[0]))
    else $error("terminate request wrong");
  chk_reset_values: assert property ($rose(rstn) |-> cache_line_size[1] == 8'h00
    && initiator_latency_limit[1] == 8'h00 && socket_window_base[1] == 32'h0)
    else $error("register not zero after reset");

  cov_write: cover property (cfg_req && cfg_write);
  cov_expired: cover property ($rose(latency_expired[0]));
  cov_legacy: cover property (legacy_reg_hit[0]);
endmodule

bind cardbus_bridge_config_header cardbus_cfg_asserts chk_u (.ref_clk(ref_clk), .rstn(rstn),
  .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .ext_sel(ext_sel), .pm_sel(pm_sel), .mem_valid(mem_valid),
  .mem_addr(mem_addr), .mem_space_en(mem_space_en), .socket_reg_hit(socket_reg_hit),
  .legacy_reg_hit(legacy_reg_hit), .init_frame_start(init_frame_start),
  .init_done(init_done), .gnt_n(gnt_n), .latency_expired(latency_expired),
  .terminate_req(terminate_req), .cache_line_size(cache_line_size),
  .initiator_latency_limit(initiator_latency_limit),
  .socket_window_base(socket_window_base));

// File: testbench.sv
/*
  Self-checking testbench of the header slice. Assumes the host model and checker.
*/
`timescale 1ns/1ps
module testbench;
  import cardbus_cfg_pkg::*;
  logic ref_clk, rstn, cfg_req, cfg_write, cfg_func, cfg_ack, ext_sel, pm_sel, mem_valid, gnt_n;
  logic [7:0] cfg_addr, a, lim;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, ext_rdata, mem_addr, d, e;
  logic [1:0] mem_space_en, socket_reg_hit, legacy_reg_hit, init_frame_start, init_done;
  logic [1:0] latency_expired, terminate_req, card_bus_master, parity_response_en;
  logic [1:0] ev [6];
  logic [7:0] cache_line_size [2], initiator_latency_limit [2];
  logic [31:0] socket_window_base [2], bs [2];
  logic [31:0] exp_q [$];
  string name_q [$];
  int err_count, n_compared, n;
  int sbit [6] = '{15, 14, 13, 12, 11, 8};
  logic [31:0] ofs [5] = '{32'h000, 32'h7FF, 32'h800, 32'hFFF, 32'h1000};

  cardbus_bridge_config_header dut_u (.ref_clk(ref_clk), .rstn(rstn), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ext_sel(ext_sel),
    .pm_sel(pm_sel), .ext_rdata(ext_rdata), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_space_en(mem_space_en), .socket_reg_hit(socket_reg_hit),
    .legacy_reg_hit(legacy_reg_hit), .init_frame_start(init_frame_start),
    .init_done(init_done), .gnt_n(gnt_n), .latency_expired(latency_expired),
    .terminate_req(terminate_req), .card_parity_detected(ev[0]), .card_system_error(ev[1]),
    .card_master_abort_received(ev[2]), .card_target_abort_received(ev[3]),
    .card_target_abort_signaled(ev[4]), .card_parity_signal(ev[5]),
    .card_bus_master(card_bus_master), .parity_response_en(parity_response_en),
    .cache_line_size(cache_line_size), .initiator_latency_limit(initiator_latency_limit),
    .socket_window_base(socket_window_base));

  cfg_host_model host_u (.ref_clk(ref_clk), .rstn(rstn), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .ext_sel(ext_sel), .ext_rdata(ext_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Every answer gets a note; writes answer zero.
  task automatic acc(input string what, input logic wr, input logic fn, input logic [7:0] ad,
      input logic [3:0] be, input logic [31:0] wd, input logic [31:0] exp);
    logic ok;
    name_q.push_back(what);
    exp_q.push_back(wr ? 32'h0 : exp);
    host_u.access(wr, fn, ad, be, wd, ok);
    check("answer", {31'h0, ok}, 32'h1);
  endtask

  always @(posedge ref_clk)
    if (rstn && cfg_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare answer", 32'h1, 32'h0);
      else
        check(name_q.pop_front(), cfg_rdata, exp_q.pop_front());
    end

  initial
  begin
    rstn = 1'b0;
    mem_valid = 1'b0;
    mem_addr = 32'h0;
    mem_space_en = 2'b00;
    init_frame_start = 2'b00;
    init_done = 2'b00;
    gnt_n = 1'b0;
    card_bus_master = 2'b01;
    parity_response_en = 2'b00;
    ev = '{default: 2'b00};
    void'($urandom(47044));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      acc("hdr", 0, f[0], 8'h0C, 4'hF, 0, 32'h00820000);
      acc("base", 0, f[0], 8'h10, 4'hF, 0, 32'h0);
      acc("cap", 0, f[0], 8'h14, 4'hF, 0, 32'h020000A0);
      acc("gap wr", 1, f[0], 8'h18, 4'hF, 32'hFFFFFFFF, 0);
      acc("gap", 0, f[0], 8'h18, 4'hF, 0, 32'h0);
    end
    $display("test reset done");
    for (int f = 0; f < 2; f++)
    begin
      d = $urandom();
      acc("hdr wr", 1, f[0], 8'h0C, 4'hF, d, 0);
      acc("hdr", 0, f[0], 8'h0C, 4'hF, 0, {16'h0082, d[15:0]});
      acc("clsz wr", 1, f[0], 8'h0C, 4'h1, ~d, 0);
      acc("hdr", 0, f[0], 8'h0C, 4'hF, 0, {16'h0082, d[15:8], ~d[7:0]});
      check("clsz out", {24'h0, cache_line_size[f]}, {24'h0, ~d[7:0]});
      acc("base wr", 1, f[0], 8'h10, 4'hF, 32'hFFFFFFFF, 0);
      acc("base", 0, f[0], 8'h10, 4'hF, 0, 32'hFFFFF000);
      bs[f] = $urandom() & 32'hFFFFF000;
      acc("base wr", 1, f[0], 8'h10, 4'hF, bs[f] | 32'h00000ABC, 0);
      acc("cap wr", 1, f[0], 8'h14, 4'hF, 32'hFFFFFFFF, 0);
      acc("cap", 0, f[0], 8'h14, 4'hF, 0, 32'h020000A0);
    end
    for (int f = 0; f < 2; f++)
      check("base out", socket_window_base[f], bs[f]);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      a = (i < 2) ? 8'hA0 + 8'(4 * i) : 8'h80 | 8'($urandom());
      acc("ext", i[0], 1'b0, a, 4'hF, 0, {~a, a, 16'hC35A});
    end
    $display("test extension done");
    @(posedge ref_clk);
    mem_valid <= 1'b1;
    mem_space_en <= 2'b11;
    for (int f = 0; f < 3; f++)
      for (int i = 0; i < 5; i++)
      begin
        @(posedge ref_clk);
        mem_addr <= bs[f % 2] + ofs[i];
        if (f == 2)
          mem_space_en <= 2'b00;
        @(negedge ref_clk);
        e = (f < 2 && i < 2) ? 32'h1 << f : 32'h0;
        check("socket hit", {30'h0, socket_reg_hit}, e);
        e = (f < 2 && (i == 2 || i == 3)) ? 32'h1 << f : 32'h0;
        check("legacy hit", {30'h0, legacy_reg_hit}, e);
      end
    $display("test window done");
    for (int i = 0; i < 2; i++)
    begin
      lim = (i == 0) ? 8'h00 : 8'($urandom_range(6, 1));
      acc("lat wr", 1, 0, 8'h0D, 4'h2, {16'h0, lim, 8'h55}, 0);
      @(posedge ref_clk);
      init_frame_start <= 2'b01;
      @(posedge ref_clk);
      init_frame_start <= 2'b00;
      n = 1;
      @(negedge ref_clk);
      while (latency_expired[0] !== 1'b1 && n < 300)
      begin
        @(negedge ref_clk);
        n++;
      end
      check("expiry cycle", 32'(n), 32'(lim) + 32'h2);
      if (n >= 300)
        complete_run();
      check("expired", {30'h0, latency_expired}, 32'h1);
      check("terminate", {30'h0, terminate_req}, 32'h0);
      @(posedge ref_clk);
      gnt_n <= 1'b1;
      @(negedge ref_clk);
      check("terminate", {30'h0, terminate_req}, 32'h1);
      @(posedge ref_clk);
      init_done <= 2'b01;
      gnt_n <= 1'b0;
      @(posedge ref_clk);
      init_done <= 2'b00;
      @(negedge ref_clk);
      check("expired", {30'h0, latency_expired}, 32'h0);
    end
    $display("test latency done");
    for (int b = 0; b < 8; b++)
    begin
      @(posedge ref_clk);
      ev[(b > 5) ? 5 : b] <= 2'b01;
      parity_response_en <= {1'b0, b != 6};
      card_bus_master <= {1'b0, b != 7};
      @(posedge ref_clk);
      ev[(b > 5) ? 5 : b] <= 2'b00;
      e = (b > 5) ? 32'h020000A0 : 32'h020000A0 | (32'h1 << (16 + sbit[b]));
      acc("status", 0, 0, 8'h14, 4'hF, 0, e);
      acc("status other", 0, 1, 8'h14, 4'hF, 0, 32'h020000A0);
      acc("zero wr", 1, 0, 8'h14, 4'hC, 32'h0, 0);
      acc("status", 0, 0, 8'h14, 4'hF, 0, e);
      acc("clear wr", 1, 0, 8'h14, 4'hC, e, 0);
      acc("status", 0, 0, 8'h14, 4'hF, 0, 32'h020000A0);
    end
    $display("test status done");
    repeat (2) @(posedge ref_clk);
    check("notes left", exp_q.size(), 32'h0);
    complete_run();
  end
endmodule
